//--- hw/ppt_pkg.sv
package ppt_pkg;
  // Register byte offsets on the bus
  localparam logic [7:0] OFF_CS1_BASE = 8'h00;
  localparam logic [7:0] OFF_CS2_BASE = 8'h04;
  localparam logic [7:0] OFF_CS1_MODE = 8'h08;
  localparam logic [7:0] OFF_CS2_MODE = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [7:0] OFF_PADCFG = 8'h14;
  localparam logic [7:0] OFF_MCTL = 8'h18;
  localparam logic [7:0] OFF_MDATA = 8'h1C;
  localparam logic [7:0] OFF_IN_BUF = 8'h20;
  localparam logic [7:0] OFF_OUT_BUF = 8'h24;

  // Reset values and implemented-bit masks
  localparam logic [15:0] CS1_BASE_RST = 16'h0200;
  localparam logic [15:0] CS2_BASE_RST = 16'h0600;
  localparam logic [15:0] BASE_MASK = 16'hFF88;
  localparam logic [15:0] MODE_RST = 16'h0000;
  localparam logic [15:0] MODE_MASK = 16'hF8FF;
  localparam logic [15:0] PADCFG_MASK = 16'h0001;

  // Field positions
  localparam int BASE_HI_LSB = 7;
  localparam int BASE_B11_POS = 3;
  localparam int STAT_OVF_POS = 14;
  localparam int STAT_UNF_POS = 6;
  localparam int MCTL_WR_POS = 24;
  localparam int MCTL_ALT_POS = 25;
  localparam int MCTL_TMO_POS = 30;
  localparam int MCTL_BUSY_POS = 31;

  // Acknowledge mode codes
  localparam logic [1:0] ACK_IGNORE = 2'b00;
  localparam logic [1:0] ACK_TMO = 2'b01;
  localparam logic [1:0] ACK_WAIT = 2'b10;

  // Timing: clock rate, instruction cycle and derived counts
  localparam int CLK_HZ = 20_000_000;
  localparam int TCY_NS = 200;
  localparam int TCY_CLKS = TCY_NS * (CLK_HZ / 1_000_000) / 1000;
  localparam int ACK_TMO_DEF_TCY = 255;
  localparam int AM_WAIT_BASE = 3;
  localparam int AM_CYC_CLKS = 1;
  localparam int CNT_W = 12;

  // Per chip-select mode register layout
  typedef struct packed {
    logic [1:0] ack_mode_sel;
    logic [2:0] alt_master_wait;
    logic [2:0] unused;
    logic [1:0] data_setup_wait;
    logic [3:0] strobe_wait;
    logic [1:0] data_hold_wait;
  } ppt_mode_t;

  // Pending master transfer
  typedef struct packed {
    logic [23:0] addr;
    logic wr;
    logic alt;
  } ppt_req_t;

  // Parallel pin group driven by the master sequencer
  typedef struct packed {
    logic cs1;
    logic cs2;
    logic rd_strobe;
    logic wr_strobe;
    logic data_oe;
  } ppt_pins_t;

  typedef enum {ST_IDLE, ST_AMW, ST_SETUP, ST_STROBE, ST_HOLD} ppt_state_t;
endpackage

//--- hw/ppt_core.sv
// Contract
// - Base register keeps address 23:15 in bits 15:7, address 11 in bit 3.
// - Reset loads chip select 1 base 0x0200 and chip select 2 base 0x0600.
// - Chip select 2 base of zero lets chip select 1 reach the top.
// - Ack mode 10 waits for acknowledge, 00 ignores it, 11 reserved.
// - Ack mode 01 waits with time-out: 255 Tcy or strobe wait field.
// - Alternate master wait is three plus field value master cycles.
// - Data setup before strobe is field plus one quarter Tcy.
// - Write strobe lasts field plus one half Tcy.
// - Read strobe lasts field plus three quarters Tcy.
// - Write data hold after strobe is field plus one quarter Tcy.
// - Input-all-full reads one only when every input buffer holds data.
// - Host write into a full input buffer sets sticky overflow.
// - Per-buffer input flag sets on host write, clears on software read.
// - Output-all-empty reads one only when every output buffer is empty.
// - Host read of an empty output buffer sets sticky underflow.
// - Per-buffer output-empty flag clears on software write, resets to one.
// - Byte access clears flags of both bytes of the word pair.
// - Pad configuration bit 0 selects TTL or Schmitt port input buffers.
//
// Register access over AHB-Lite and the register offsets were left to the implementer.
`timescale 1ns/100ps
module ppt_core
  import ppt_pkg::*;
(
  // Clock, reset, enable
  input wire logic clock,
  input wire logic reset,
  input wire logic clk_en,
  // AHB-Lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  // Parallel master pins
  output logic [23:0] pm_addr,
  input wire logic [15:0] port_data_in,
  output logic [15:0] port_data_out,
  output logic port_data_oe,
  output logic rd_strobe,
  output logic wr_strobe,
  output logic chip_select_one,
  output logic chip_select_two,
  input wire logic ext_ack_in,
  // Slave-mode host port
  input wire logic host_wr_stb,
  input wire logic host_rd_stb,
  input wire logic [1:0] host_buf_sel,
  input wire logic [7:0] host_wdata,
  output logic [7:0] host_rdata,
  // Pad control
  output logic port_input_ttl_sel
);

  // Byte lanes touched by an AHB access
  function automatic logic [3:0] lanes_of(input logic [2:0] sz,
                                          input logic [1:0] a);
    logic [3:0] m;
    m = 4'h0;
    case (sz)
      3'h0: m[a] = 1'b1;
      3'h1: m = a[1] ? 4'hC : 4'h3;
      default: m = 4'hF;
    endcase
    return m;
  endfunction

  // Widen a lane mask to whole word pairs
  function automatic logic [3:0] pair_of(input logic [3:0] m);
    return {{2{m[3] | m[2]}}, {2{m[1] | m[0]}}};
  endfunction

  // Merge a lane-masked write into a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] wd,
                                          input logic [3:0] ln,
                                          input logic [15:0] mask);
    logic [15:0] r;
    r = old;
    if (ln[0]) r[7:0] = wd[7:0];
    if (ln[1]) r[15:8] = wd[15:8];
    return r & mask;
  endfunction

  // Decoded 24-bit base address of a chip select
  function automatic logic [23:0] base_of(input logic [15:0] r);
    return {r[15:BASE_HI_LSB], 3'h0, r[BASE_B11_POS], 11'h000};
  endfunction

  localparam logic [CNT_W-1:0] TCY_C = CNT_W'(TCY_CLKS);

  // Bus, register and buffer state
  logic ap_valid_q, ap_valid_d;
  logic ap_write_q, ap_write_d;
  logic [7:0] ap_off_q, ap_off_d;
  logic [3:0] ap_lanes_q, ap_lanes_d;
  logic [31:0] hrdata_q, hrdata_d;
  logic [15:0] cs1_base_q, cs1_base_d, cs2_base_q, cs2_base_d;
  logic [15:0] cs1_mode_q, cs1_mode_d, cs2_mode_q, cs2_mode_d;
  logic pad_ttl_q, pad_ttl_d;
  logic [3:0] in_full_q, in_full_d, out_empty_q, out_empty_d;
  logic ovf_q, ovf_d, unf_q, unf_d;
  logic [7:0] in_buf_q [4];
  logic [7:0] in_buf_d [4];
  logic [7:0] out_buf_q [4];
  logic [7:0] out_buf_d [4];
  logic [7:0] host_rdata_q, host_rdata_d;
  ppt_req_t req_q, req_d;
  logic [15:0] mwdata_q, mwdata_d, mrdata_q, mrdata_d;
  logic start_q, start_d;
  // Master sequencer state
  ppt_state_t st_q, st_d;
  logic [CNT_W-1:0] cnt_q, cnt_d, tmo_q, tmo_d;
  logic cs2_sel_q, cs2_sel_d, tmo_flag_q, tmo_flag_d;
  ppt_pins_t pins_q, pins_d;

  logic ap_take, wr_dp, busy;
  logic [15:0] status;
  logic [23:0] b1, b2;
  logic hit2, hit1;
  ppt_mode_t md;
  logic [CNT_W-1:0] n_setup, n_strobe, n_hold, n_amw, n_tmo;
  logic min_done, ack_ok, tmo_hit;

  assign busy = (st_q != ST_IDLE);
  assign ap_take = hsel & hready & htrans[1];
  assign wr_dp = ap_valid_q & ap_write_q;
  assign status = {&in_full_q, ovf_q, 2'h0, in_full_q,
                   &out_empty_q, unf_q, 2'h0, out_empty_q};

  // Bus, register file and slave buffers: next values
  always_comb begin
    ap_valid_d = ap_take;
    ap_write_d = hwrite;
    ap_off_d = haddr[7:0];
    ap_lanes_d = lanes_of(hsize, haddr[1:0]);
    hrdata_d = hrdata_q;
    cs1_base_d = cs1_base_q;
    cs2_base_d = cs2_base_q;
    cs1_mode_d = cs1_mode_q;
    cs2_mode_d = cs2_mode_q;
    pad_ttl_d = pad_ttl_q;
    in_buf_d = in_buf_q;
    out_buf_d = out_buf_q;
    host_rdata_d = host_rdata_q;
    req_d = req_q;
    mwdata_d = mwdata_q;
    start_d = 1'b0;
    in_full_d = in_full_q;
    out_empty_d = out_empty_q;
    ovf_d = ovf_q;
    unf_d = unf_q;
    // Address phase of a read: sample data and apply read side effects
    if (ap_take && !hwrite) begin
      case (haddr[7:0])
        OFF_CS1_BASE: hrdata_d = {16'h0000, cs1_base_q};
        OFF_CS2_BASE: hrdata_d = {16'h0000, cs2_base_q};
        OFF_CS1_MODE: hrdata_d = {16'h0000, cs1_mode_q};
        OFF_CS2_MODE: hrdata_d = {16'h0000, cs2_mode_q};
        OFF_STATUS: hrdata_d = {16'h0000, status};
        OFF_PADCFG: hrdata_d = {31'h0, pad_ttl_q};
        OFF_MCTL: hrdata_d = {busy, tmo_flag_q, 4'h0, req_q.alt, req_q.wr,
                              req_q.addr};
        OFF_MDATA: hrdata_d = {16'h0000, mrdata_q};
        OFF_IN_BUF: begin
          hrdata_d = {in_buf_q[3], in_buf_q[2], in_buf_q[1], in_buf_q[0]};
          in_full_d = in_full_q & ~pair_of(ap_lanes_d);
        end
        OFF_OUT_BUF: hrdata_d = {out_buf_q[3], out_buf_q[2], out_buf_q[1],
                                 out_buf_q[0]};
        default: hrdata_d = 32'h0000_0000;
      endcase
    end
    // Data phase of a write
    if (wr_dp) begin
      case (ap_off_q)
        OFF_CS1_BASE:
          cs1_base_d = merge16(cs1_base_q, hwdata, ap_lanes_q, BASE_MASK);
        OFF_CS2_BASE:
          cs2_base_d = merge16(cs2_base_q, hwdata, ap_lanes_q, BASE_MASK);
        OFF_CS1_MODE:
          cs1_mode_d = merge16(cs1_mode_q, hwdata, ap_lanes_q, MODE_MASK);
        OFF_CS2_MODE:
          cs2_mode_d = merge16(cs2_mode_q, hwdata, ap_lanes_q, MODE_MASK);
        OFF_STATUS: begin
          if (ap_lanes_q[1] && !hwdata[STAT_OVF_POS]) ovf_d = 1'b0;
          if (ap_lanes_q[0] && !hwdata[STAT_UNF_POS]) unf_d = 1'b0;
        end
        OFF_PADCFG:
          if (ap_lanes_q[0]) pad_ttl_d = hwdata[0];
        OFF_MCTL:
          if (!busy) begin
            req_d = {hwdata[23:0], hwdata[MCTL_WR_POS], hwdata[MCTL_ALT_POS]};
            start_d = 1'b1;
          end
        OFF_MDATA: mwdata_d = merge16(mwdata_q, hwdata, ap_lanes_q,
                                      16'hFFFF);
        OFF_OUT_BUF: begin
          for (int i = 0; i < 4; i++) begin
            if (ap_lanes_q[i]) out_buf_d[i] = hwdata[8*i +: 8];
          end
          out_empty_d = out_empty_q & ~pair_of(ap_lanes_q);
        end
        default: ;
      endcase
    end
    // Host writes input buffers; a full target flags overflow
    if (host_wr_stb) begin
      if (in_full_q[host_buf_sel]) begin
        ovf_d = 1'b1;
      end else begin
        in_buf_d[host_buf_sel] = host_wdata;
        in_full_d[host_buf_sel] = 1'b1;
      end
    end
    // Host reads output buffers; an empty source flags underflow
    if (host_rd_stb) begin
      if (out_empty_q[host_buf_sel]) begin
        unf_d = 1'b1;
      end else begin
        host_rdata_d = out_buf_q[host_buf_sel];
        out_empty_d[host_buf_sel] = 1'b1;
      end
    end
  end

  // Bus, register file and slave buffers: registers
  always_ff @(posedge clock) begin
    if (reset) begin
      ap_valid_q <= 1'b0;
      ap_write_q <= 1'b0;
      ap_off_q <= 8'h00;
      ap_lanes_q <= 4'h0;
      hrdata_q <= 32'h0000_0000;
      cs1_base_q <= CS1_BASE_RST;
      cs2_base_q <= CS2_BASE_RST;
      cs1_mode_q <= MODE_RST;
      cs2_mode_q <= MODE_RST;
      pad_ttl_q <= 1'b0;
      in_full_q <= 4'h0;
      out_empty_q <= 4'hF;
      ovf_q <= 1'b0;
      unf_q <= 1'b0;
      in_buf_q <= '{default: 8'h00};
      out_buf_q <= '{default: 8'h00};
      host_rdata_q <= 8'h00;
      req_q <= '0;
      mwdata_q <= 16'h0000;
      start_q <= 1'b0;
    end else if (clk_en) begin
      ap_valid_q <= ap_valid_d;
      ap_write_q <= ap_write_d;
      ap_off_q <= ap_off_d;
      ap_lanes_q <= ap_lanes_d;
      hrdata_q <= hrdata_d;
      cs1_base_q <= cs1_base_d;
      cs2_base_q <= cs2_base_d;
      cs1_mode_q <= cs1_mode_d;
      cs2_mode_q <= cs2_mode_d;
      pad_ttl_q <= pad_ttl_d;
      in_full_q <= in_full_d;
      out_empty_q <= out_empty_d;
      ovf_q <= ovf_d;
      unf_q <= unf_d;
      in_buf_q <= in_buf_d;
      out_buf_q <= out_buf_d;
      host_rdata_q <= host_rdata_d;
      req_q <= req_d;
      mwdata_q <= mwdata_d;
      start_q <= start_d;
    end
  end

  // Chip-select decode of the pending address
  always_comb begin
    b1 = base_of(cs1_base_q);
    b2 = base_of(cs2_base_q);
    hit2 = (cs2_base_q != 16'h0000) && (req_q.addr >= b2);
    hit1 = !hit2 && (req_q.addr >= b1);
  end

  // Phase lengths in quarter-Tcy clocks for the selected chip select
  always_comb begin
    md = ppt_mode_t'(((st_q == ST_IDLE) ? hit2 : cs2_sel_q) ? cs2_mode_q
                                                             : cs1_mode_q);
    n_setup = TCY_C * CNT_W'(md.data_setup_wait) + CNT_W'(1);
    n_strobe = TCY_C * CNT_W'(md.strobe_wait)
             + (req_q.wr ? CNT_W'(2) : CNT_W'(3));
    n_hold = TCY_C * CNT_W'(md.data_hold_wait)
           + (req_q.wr ? CNT_W'(1) : CNT_W'(0));
    n_amw = CNT_W'(AM_CYC_CLKS)
          * (CNT_W'(AM_WAIT_BASE) + CNT_W'(md.alt_master_wait));
    n_tmo = TCY_C * ((md.strobe_wait == 4'h0) ? CNT_W'(ACK_TMO_DEF_TCY)
                                               : CNT_W'(md.strobe_wait));
  end

  // Strobe termination by count, acknowledge or time-out
  always_comb begin
    min_done = (cnt_q == '0);
    case (md.ack_mode_sel)
      ACK_WAIT, ACK_TMO: ack_ok = ext_ack_in;
      default: ack_ok = 1'b1;
    endcase
    tmo_hit = (md.ack_mode_sel == ACK_TMO) && (tmo_q == '0);
  end

  // Master sequencer: next state
  always_comb begin
    st_d = st_q;
    cnt_d = (cnt_q != '0) ? cnt_q - CNT_W'(1) : cnt_q;
    tmo_d = (tmo_q != '0) ? tmo_q - CNT_W'(1) : tmo_q;
    cs2_sel_d = cs2_sel_q;
    tmo_flag_d = tmo_flag_q;
    mrdata_d = mrdata_q;
    case (st_q)
      ST_IDLE:
        if (start_q) begin
          cs2_sel_d = hit2;
          tmo_flag_d = 1'b0;
          if (req_q.alt) begin
            st_d = ST_AMW;
            cnt_d = n_amw - CNT_W'(1);
          end else begin
            st_d = ST_SETUP;
            cnt_d = n_setup - CNT_W'(1);
          end
        end
      ST_AMW:
        if (min_done) begin
          st_d = ST_SETUP;
          cnt_d = n_setup - CNT_W'(1);
        end
      ST_SETUP:
        if (min_done) begin
          st_d = ST_STROBE;
          cnt_d = n_strobe - CNT_W'(1);
          tmo_d = n_tmo - CNT_W'(1);
        end
      ST_STROBE:
        if (min_done && (ack_ok || tmo_hit)) begin
          if (!req_q.wr) mrdata_d = port_data_in;
          if (!ack_ok) tmo_flag_d = 1'b1;
          if (n_hold == '0) begin
            st_d = ST_IDLE;
          end else begin
            st_d = ST_HOLD;
            cnt_d = n_hold - CNT_W'(1);
          end
        end
      ST_HOLD:
        if (min_done) st_d = ST_IDLE;
      default: st_d = ST_IDLE;
    endcase
    // Pin levels follow the next state so they come from flops
    pins_d.cs1 = (st_d inside {ST_SETUP, ST_STROBE, ST_HOLD})
               && !(st_q == ST_IDLE ? hit2 : cs2_sel_q)
               && hit1;
    pins_d.cs2 = (st_d inside {ST_SETUP, ST_STROBE, ST_HOLD})
               && (st_q == ST_IDLE ? hit2 : cs2_sel_q);
    pins_d.rd_strobe = (st_d == ST_STROBE) && !req_q.wr;
    pins_d.wr_strobe = (st_d == ST_STROBE) && req_q.wr;
    pins_d.data_oe = (st_d inside {ST_SETUP, ST_STROBE, ST_HOLD})
                   && req_q.wr;
  end

  // Master sequencer: registers
  always_ff @(posedge clock) begin
    if (reset) begin
      st_q <= ST_IDLE;
      cnt_q <= '0;
      tmo_q <= '0;
      cs2_sel_q <= 1'b0;
      tmo_flag_q <= 1'b0;
      mrdata_q <= 16'h0000;
      pins_q <= '0;
    end else if (clk_en) begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      tmo_q <= tmo_d;
      cs2_sel_q <= cs2_sel_d;
      tmo_flag_q <= tmo_flag_d;
      mrdata_q <= mrdata_d;
      pins_q <= pins_d;
    end
  end

  // Outputs
  assign hreadyout = clk_en;
  assign hrdata = hrdata_q;
  assign hresp = 1'b0;
  assign pm_addr = req_q.addr;
  assign port_data_out = mwdata_q;
  assign port_data_oe = pins_q.data_oe;
  assign rd_strobe = pins_q.rd_strobe;
  assign wr_strobe = pins_q.wr_strobe;
  assign chip_select_one = pins_q.cs1;
  assign chip_select_two = pins_q.cs2;
  assign host_rdata = host_rdata_q;
  assign port_input_ttl_sel = pad_ttl_q;

endmodule // ppt_core

//--- verif/ppt_core_checker.sv
`timescale 1ns/100ps
module ppt_core_checker
  import ppt_pkg::*;
(
  // Clock, reset, enable
  input wire logic clock,
  input wire logic reset,
  input wire logic clk_en,
  // Bus side
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // Parallel pins
  input wire logic port_data_oe,
  input wire logic rd_strobe,
  input wire logic wr_strobe,
  input wire logic chip_select_one,
  input wire logic chip_select_two,
  input wire logic port_input_ttl_sel
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (reset);
  logic pad_wr_q, pad_wr_d;
  wire logic cs_any = chip_select_one | chip_select_two;
  // Remember a taken write address phase to the pad register
  always_comb begin
    pad_wr_d = pad_wr_q;
    if (hreadyout) begin
      pad_wr_d = hsel && htrans[1] && hwrite && haddr[7:0] == OFF_PADCFG;
    end
    if (reset) begin
      pad_wr_d = 1'b0;
    end
  end
  always_ff @(posedge clock) begin
    pad_wr_q <= pad_wr_d;
  end
  sequence s_wr_start; $rose(wr_strobe); endsequence
  sequence s_rd_start; $rose(rd_strobe); endsequence
  sequence s_any_start; $rose(rd_strobe | wr_strobe); endsequence
  chk_resp_okay: assert property (hresp == 1'b0)
    else $error("bus response not okay");
  chk_ready_enable: assert property (hreadyout == clk_en)
    else $error("ready does not follow enable");
  chk_cs_exclusive: assert property (
    !(chip_select_one && chip_select_two))
    else $error("both chip selects active");
  chk_setup_first: assert property (
    s_any_start |-> $past(cs_any))
    else $error("strobe without setup clock");
  chk_wr_width: assert property (
    s_wr_start |=> wr_strobe)
    else $error("write strobe shorter than two clocks");
  chk_rd_width: assert property (
    s_rd_start |=> rd_strobe [*2])
    else $error("read strobe shorter than three clocks");
  chk_wr_hold: assert property (
    $fell(wr_strobe) |-> port_data_oe && cs_any)
    else $error("write data not held after strobe");
  chk_strobe_cs: assert property (
    (rd_strobe || wr_strobe) |-> cs_any && !(rd_strobe && wr_strobe))
    else $error("strobe outside chip select");
  chk_read_nodrive: assert property (
    rd_strobe |-> !port_data_oe)
    else $error("data driven during read");
  chk_ttl_update: assert property (
    pad_wr_q && hreadyout |=> port_input_ttl_sel == $past(hwdata[0]))
    else $error("pad select not updated by write");
endmodule // ppt_core_checker

bind ppt_core ppt_core_checker u_chk (.clock, .reset, .clk_en, .hsel,
  .haddr, .htrans, .hwrite, .hwdata, .hreadyout, .hresp, .port_data_oe,
  .rd_strobe, .wr_strobe, .chip_select_one, .chip_select_two,
  .port_input_ttl_sel);

//--- verif/ppt_ext_mem.sv
`timescale 1ns/100ps
module ppt_ext_mem
  import ppt_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Master pins from the port
  input wire logic [23:0] pm_addr,
  input wire logic [15:0] port_data_out,
  input wire logic rd_strobe,
  input wire logic wr_strobe,
  input wire logic chip_select_one,
  input wire logic chip_select_two,
  // Answers back to the port
  output logic [15:0] port_data_in,
  output logic ext_ack_in,
  // Behaviour knobs
  input wire logic ack_en,
  input wire logic [7:0] ack_dly
);
  logic [15:0] mem_q [16];
  logic [15:0] last_q;
  logic [7:0] cnt_q;
  wire logic sel = chip_select_one | chip_select_two;
  // Data only while selected and read, else a pattern that keeps changing
  assign port_data_in = (sel && rd_strobe) ? mem_q[pm_addr[3:0]] : ~last_q;
  // Acknowledge after a set number of strobe clocks, or never
  assign ext_ack_in = ack_en && (rd_strobe || wr_strobe)
                      && cnt_q >= ack_dly;
  // Strobe clock counter, released-bus pattern and storage
  always_ff @(posedge clock) begin
    last_q <= reset ? 16'h5A5A : port_data_in;
    if (reset || !(rd_strobe || wr_strobe)) begin
      cnt_q <= 8'h00;
    end else begin
      cnt_q <= cnt_q + 8'h01;
    end
    if (sel && wr_strobe) begin
      mem_q[pm_addr[3:0]] <= port_data_out;
    end
  end
endmodule // ppt_ext_mem

//--- verif/test_parallel_port_chip_select_timing.sv
`timescale 1ns/100ps
`define CHK(got, exp) begin \
  num_checks++; \
  if ((got) !== (exp)) begin \
    miscompares++; \
    $display("[FAIL] t=%0t got %h exp %h", $time, got, exp); \
  end \
end
module test_parallel_port_chip_select_timing
  import ppt_pkg::*;
;
  logic clock, reset, clk_en, hsel, hwrite, hreadyout, hresp;
  logic [31:0] haddr, hwdata, hrdata, r, rdat, mexp;
  logic [1:0] htrans, host_buf_sel;
  logic [2:0] hsize;
  logic [23:0] pm_addr;
  logic [15:0] port_data_in, port_data_out;
  logic port_data_oe, rd_strobe, wr_strobe, cs1, cs2, ext_ack_in, ttl;
  logic host_wr_stb, host_rd_stb, ack_en, rd_ph, c1;
  logic [7:0] host_wdata, host_rdata, ack_dly;
  logic [31:0] exp_q [$];
  int miscompares, num_checks, cycles, seed, lead0, lead1, su, st, ho;

  ppt_core DUT (.clock(clock), .reset(reset), .clk_en(clk_en),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
    .pm_addr(pm_addr), .port_data_in(port_data_in),
    .port_data_out(port_data_out), .port_data_oe(port_data_oe),
    .rd_strobe(rd_strobe), .wr_strobe(wr_strobe),
    .chip_select_one(cs1), .chip_select_two(cs2), .ext_ack_in(ext_ack_in),
    .host_wr_stb(host_wr_stb), .host_rd_stb(host_rd_stb),
    .host_buf_sel(host_buf_sel), .host_wdata(host_wdata),
    .host_rdata(host_rdata), .port_input_ttl_sel(ttl));
  ppt_ext_mem u_mem (.clock(clock), .reset(reset), .pm_addr(pm_addr),
    .port_data_out(port_data_out), .rd_strobe(rd_strobe),
    .wr_strobe(wr_strobe), .chip_select_one(cs1), .chip_select_two(cs2),
    .port_data_in(port_data_in), .ext_ack_in(ext_ack_in),
    .ack_en(ack_en), .ack_dly(ack_dly));

  // Clock generator
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  task automatic stop_test;
    $display("checks %0d miscompares %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // One single word transfer; a checked read leaves its note in the queue
  task automatic ahb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, input logic c,
                     input logic [31:0] e);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h000000, a};
    @(posedge clock);
    while (!hreadyout) @(posedge clock);
    htrans <= 2'h0;
    hsel <= 1'b0;
    hwdata <= d;
    if (c) begin
      exp_q.push_back(e);
      rd_ph <= 1'b1;
    end
    @(posedge clock);
    while (!hreadyout) @(posedge clock);
    rdat = hrdata;
    rd_ph <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    ahb(1'b0, a, 32'h0, 1'b1, e);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    ahb(1'b1, a, d, 1'b0, 32'h0);
  endtask

  // One-clock host strobe into or out of a slave buffer
  task automatic host(input logic w, input logic [1:0] s,
                      input logic [7:0] d);
    @(posedge clock);
    host_wr_stb <= w;
    host_rd_stb <= !w;
    host_buf_sel <= s;
    host_wdata <= d;
    @(posedge clock);
    host_wr_stb <= 1'b0;
    host_rd_stb <= 1'b0;
  endtask

  // Clocks to chip select, then setup, strobe and hold lengths
  task automatic meas(output int lead);
    lead = 0;
    su = 0;
    st = 0;
    ho = 0;
    while (!(cs1 | cs2)) begin @(posedge clock); lead++; end
    c1 = cs1;
    while (!(rd_strobe | wr_strobe)) begin @(posedge clock); su++; end
    while (rd_strobe | wr_strobe) begin @(posedge clock); st++; end
    while (cs1 | cs2) begin @(posedge clock); ho++; end
  endtask

  function automatic logic [31:0] mode(input logic [1:0] a,
      input logic [2:0] m, input logic [1:0] b, input logic [3:0] s,
      input logic [1:0] e);
    ppt_mode_t t;
    t = '{a, m, 3'h0, b, s, e};
    return {16'h0000, t};
  endfunction

  // Read data checker: oldest note against the completed data phase
  always @(posedge clock) begin
    if (rd_ph && hreadyout) begin
      mexp = exp_q.pop_front();
      `CHK(hrdata, mexp)
    end
  end

  // Hang guard
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      stop_test;
    end
  end

  initial begin
    {clk_en, reset, seed, cycles} = {1'b1, 1'b1, 32'd81, 32'd0};
    {hsel, hwrite, htrans, haddr, hwdata, hsize} = {36'h0, 32'h0, 3'h2};
    {host_wr_stb, host_rd_stb, host_buf_sel, host_wdata} = 12'h000;
    {ack_en, ack_dly, rd_ph} = {1'b0, 8'h14, 1'b0};
    repeat (6) @(posedge clock);
    reset <= 1'b0;
    rd(OFF_CS1_BASE, {16'h0000, CS1_BASE_RST});
    rd(OFF_CS2_BASE, {16'h0000, CS2_BASE_RST});
    rd(OFF_CS1_MODE, 32'h0000_0000);
    rd(OFF_STATUS, 32'h0000_008F);
    rd(8'h28, 32'h0000_0000);
    for (int i = 0; i < 4; i++) begin
      r = $random(seed);
      wr(OFF_CS2_BASE, r);
      rd(OFF_CS2_BASE, {16'h0000, r[15:0] & BASE_MASK});
      wr(OFF_CS2_MODE, r);
      rd(OFF_CS2_MODE, {16'h0000, r[15:0] & MODE_MASK});
    end
    wr(OFF_PADCFG, 32'hFFFF_FFFF);
    rd(OFF_PADCFG, 32'h0000_0001);
    `CHK(ttl, 1'b1)
    wr(OFF_CS2_BASE, 32'h0000_0000);
    wr(OFF_CS1_MODE, mode(ACK_IGNORE, 3'h0, 2'h1, 4'h2, 2'h1));
    wr(OFF_MDATA, 32'h0000_BEEF);
    wr(OFF_MCTL, 32'h01FF_0010);
    meas(lead0);
    `CHK(c1, 1'b1)
    `CHK(su, 5)
    `CHK(st, 10)
    `CHK(ho, 5)
    wr(OFF_CS1_MODE, mode(ACK_IGNORE, 3'h5, 2'h0, 4'h2, 2'h0));
    wr(OFF_MCTL, 32'h02FF_0010);
    meas(lead1);
    `CHK(lead1 - lead0, 8)
    `CHK(st, 11)
    `CHK(ho, 0)
    repeat (4) @(posedge clock);
    rd(OFF_MDATA, 32'h0000_BEEF);
    ack_en <= 1'b1;
    wr(OFF_CS1_MODE, mode(ACK_WAIT, 3'h0, 2'h0, 4'h0, 2'h0));
    wr(OFF_MCTL, 32'h00FF_0010);
    meas(lead1);
    `CHK(st >= 20 && st <= 24, 1'b1)
    ack_en <= 1'b0;
    wr(OFF_CS1_MODE, mode(ACK_TMO, 3'h0, 2'h0, 4'h3, 2'h0));
    wr(OFF_MCTL, 32'h00FF_0010);
    meas(lead1);
    repeat (4) @(posedge clock);
    ahb(1'b0, OFF_MCTL, 32'h0, 1'b0, 32'h0);
    `CHK(rdat[MCTL_TMO_POS], 1'b1)
    wr(OFF_CS1_MODE, mode(ACK_TMO, 3'h0, 2'h0, 4'h0, 2'h0));
    wr(OFF_MCTL, 32'h00FF_0010);
    meas(lead1);
    `CHK(st, TCY_CLKS * ACK_TMO_DEF_TCY)
    host(1'b1, 2'h0, 8'h11);
    host(1'b1, 2'h1, 8'h22);
    host(1'b1, 2'h2, 8'h33);
    host(1'b1, 2'h3, 8'h44);
    rd(OFF_STATUS, 32'h0000_8F8F);
    host(1'b1, 2'h0, 8'h11);
    rd(OFF_STATUS, 32'h0000_CF8F);
    rd(OFF_IN_BUF, 32'h4433_2211);
    rd(OFF_STATUS, 32'h0000_408F);
    wr(OFF_STATUS, 32'h0000_0000);
    host(1'b0, 2'h1, 8'h00);
    rd(OFF_STATUS, 32'h0000_00CF);
    wr(OFF_STATUS, 32'h0000_0000);
    wr(OFF_OUT_BUF, 32'hDDCC_BBAA);
    rd(OFF_STATUS, 32'h0000_0000);
    host(1'b0, 2'h2, 8'h00);
    @(posedge clock);
    `CHK(host_rdata, 8'hCC)
    clk_en <= 1'b0;
    repeat (3) @(posedge clock);
    clk_en <= 1'b1;
    reset <= 1'b1;
    repeat (2) @(posedge clock);
    reset <= 1'b0;
    rd(OFF_CS2_BASE, {16'h0000, CS2_BASE_RST});
    wr(OFF_MCTL, 32'h01FF_0010);
    meas(lead1);
    `CHK(c1, 1'b0)
    `CHK(st, 2)
    repeat (4) @(posedge clock);
    stop_test;
  end
endmodule // test_parallel_port_chip_select_timing
